// file: hdl/phyan_ctrl.sv
// Auto-negotiation control, status registers and isolate release
//
// How it works
// - Isolate clear releases within 100 us
// - Reset release leaves isolate within 500 us
// - Strap pin seeds advertised abilities at reset
// - Advertisement word sent in pulse bursts
// - Resolve 100FD, 100HD, 10FD, 10HD priority
// - Forced mode uses speed and duplex bits
// - Negotiation ignores speed and duplex bits
// - Summary register shows resolved speed
// - Fixed ability bits read one, T4 zero
// - Status shows complete, fault, link, preamble
// - All abilities advertised with strap high, software may clear
// - Partner register captures every page received while advertising
// - Parallel detect loads 0081h or 0021h
// - Expansion register reports page and fault
// - Control bits enable, disable, restart negotiation
// - Software may override strap via advertisement register
// - Bit 9 restarts negotiation any time bit 12 is set and the strap is taken
//
// Decided for this implementation: register access over APB.
module phyan_ctrl
  import phyan_pkg::*;
#(
  parameter int unsigned RST_ISO_CYC = RST_ISO_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [6:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic advert_strap_pin_i,
  input wire logic rx_page_valid_i,
  input wire logic [15:0] rx_page_word_i,
  input wire logic link_100_i,
  input wire logic link_10_i,
  input wire logic mac_rx_dv_i,
  input wire logic mac_tx_en_i,
  output logic mac_rx_dv_o,
  output logic line_tx_en_o,
  output logic isolate_o,
  output logic flp_enable_o,
  output logic [15:0] tx_advert_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic an_complete_o
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  // Reload value of the isolate timer after any reset
  localparam logic [14:0] ISO_RST_LD = 15'(RST_ISO_CYC - 1);

  phyan_state_t cur; // Registered state
  phyan_state_t nxt; // Next state
  logic acc; // APB access phase
  logic wr_s; // Write completes this edge
  logic rd_s; // Read completes this edge
  logic [4:0] idx; // Word index from address
  logic bad_addr; // Unmapped or unaligned
  logic [15:0] wmask; // Byte lane mask
  logic [15:0] rd16; // Read mux result
  logic [15:0] stat; // Basic status word
  logic [3:0] common; // Shared abilities of this page
  logic lnk; // Link of the selected speed
  logic link_ok; // Link valid in current mode

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Reset image of the whole state
  function automatic phyan_state_t init_s();
    phyan_state_t s;
    s = '0;
    s.ctrl = CTRL_RST;
    s.adv = ADV_RST;
    s.st = AN_OFF;
    s.iso = 1'b1;
    s.iso_cnt = ISO_RST_LD;
    return s;
  endfunction

  // Highest common mode, as {speed100, full duplex}
  function automatic logic [1:0] pick(input logic [3:0] c);
    logic [1:0] r;
    r = 2'h0;
    if (c[3]) begin
      r = 2'h3;
    end else if (c[2]) begin
      r = 2'h2;
    end else if (c[1]) begin
      r = 2'h1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // Request completes only on the edge that sees pready high
  assign acc = psel_i & penable_i;
  assign wr_s = acc & cur.pready & pwrite_i & ~cur.pslverr;
  assign rd_s = acc & cur.pready & ~pwrite_i & ~cur.pslverr;
  assign idx = paddr_i[6:2];
  assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign lnk = cur.spd100 ? link_100_i : link_10_i;
  assign link_ok = (cur.st == AN_GOOD) | ((cur.st == AN_OFF) & lnk);
  assign common = cur.adv[AB_HI:AB_LO] & rx_page_word_i[AB_HI:AB_LO];

  // Read mux and address check
  always_comb begin
    stat = STAT_FIXED;
    stat[SB_ANC] = cur.an_cmpl;
    stat[SB_RFLT] = cur.lpar[LP_RFLT] & cur.lp_an_able;
    stat[SB_LINK] = link_ok;
    bad_addr = (paddr_i[1:0] != 2'h0);
    rd16 = 16'h0000;
    case (idx)
      IDX_CTRL: begin
        rd16 = cur.ctrl;
      end
      IDX_STAT: begin
        rd16 = stat;
      end
      IDX_ADV: begin
        rd16 = cur.adv;
      end
      IDX_LPAR: begin
        rd16 = cur.lpar;
      end
      IDX_EXP: begin
        // Fault, partner next page, local next page, page, partner able
        rd16 = {11'h000, cur.pdf, cur.lpar[LP_NP], 1'b0, cur.page_rx,
                cur.lp_an_able};
      end
      IDX_PSTS: begin
        // Link, 10 Mb/s flag, duplex, complete
        rd16 = {11'h000, cur.an_cmpl, 1'b0, cur.fdx, ~cur.spd100,
                link_ok};
      end
      default: begin
        bad_addr = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt = cur;

    // Restart bit clears itself after one cycle
    nxt.ctrl[CB_RESTART] = 1'b0;

    // APB: one wait state, then answer
    nxt.pready = 1'b0;
    nxt.pslverr = 1'b0;
    if (acc && !cur.pready) begin
      nxt.pready = 1'b1;
      nxt.pslverr = bad_addr;
      nxt.prdata = {16'h0000, rd16};
    end
    // Writes; read-only words ignore them
    if (wr_s && idx == IDX_CTRL) begin
      nxt.ctrl = (cur.ctrl & ~wmask) | (pwdata_i[15:0] & wmask);
    end
    if (wr_s && idx == IDX_ADV) begin
      nxt.adv = (cur.adv & ~wmask) | (pwdata_i[15:0] & wmask);
    end
    // Reading expansion clears its sticky bits; sets below win
    if (rd_s && idx == IDX_EXP) begin
      nxt.page_rx = 1'b0;
      nxt.pdf = 1'b0;
    end

    // Strap: three stages, value taken when last two agree
    nxt.strap_sync = {cur.strap_sync[1:0], advert_strap_pin_i};
    if (!cur.strap_done) begin
      if (cur.strap_cnt != STRAP_SETTLE) begin
        nxt.strap_cnt = cur.strap_cnt + 2'h1;
      end else if (cur.strap_sync[1] == cur.strap_sync[2]) begin
        nxt.adv[AB_HI:AB_LO] = cur.strap_sync[2] ? STRAP_HI_ABIL :
                               STRAP_LO_ABIL;
        nxt.strap_done = 1'b1;
      end
    end

    // Isolate: held while bit set, timed release after
    if (cur.ctrl[CB_ISO]) begin
      nxt.iso = 1'b1;
      nxt.iso_cnt = ISO_SW_LD;
    end else if (cur.iso_cnt != 15'h0000) begin
      nxt.iso_cnt = cur.iso_cnt - 15'h0001;
    end else begin
      nxt.iso = 1'b0;
    end

    // Negotiation
    case (cur.st)
      AN_OFF: begin
        // Forced mode follows the control bits
        nxt.spd100 = cur.ctrl[CB_SPEED];
        nxt.fdx = cur.ctrl[CB_DUPLEX];
        nxt.an_cmpl = 1'b0;
        // Wait for the strap so the first burst is right
        if (cur.ctrl[CB_AN_EN] && cur.strap_done) begin
          nxt.st = AN_ADVERT;
        end
      end
      AN_ADVERT: begin
        if (rx_page_valid_i) begin
          // Every page lands in the partner register
          nxt.lpar = rx_page_word_i;
          nxt.page_rx = 1'b1;
          nxt.lp_an_able = 1'b1;
          // Last page with a shared mode resolves
          if (!rx_page_word_i[LP_NP] && common != 4'h0) begin
            {nxt.spd100, nxt.fdx} = pick(common);
            nxt.an_cmpl = 1'b1;
            nxt.st = AN_WAIT_LINK;
          end
        end else if (!cur.lp_an_able && (link_100_i ^ link_10_i)) begin
          // Partner without negotiation: parallel detect
          nxt.lpar = link_100_i ? PD_100_WORD : PD_10_WORD;
          nxt.spd100 = link_100_i;
          nxt.fdx = 1'b0;
          nxt.an_cmpl = 1'b1;
          nxt.st = AN_GOOD;
        end else if (!cur.lp_an_able && link_100_i && link_10_i) begin
          nxt.pdf = 1'b1;
        end
      end
      AN_WAIT_LINK: begin
        // Resolved mode holds; control bits play no part
        if (lnk) begin
          nxt.st = AN_GOOD;
        end
      end
      AN_GOOD: begin
        // Lost link resumes negotiation
        if (!lnk) begin
          nxt.st = AN_ADVERT;
          nxt.an_cmpl = 1'b0;
          nxt.lp_an_able = 1'b0;
        end
      end
      default: begin
        nxt.st = AN_OFF;
      end
    endcase
    // Enable and restart take priority over the sequence
    if (!cur.ctrl[CB_AN_EN]) begin
      nxt.st = AN_OFF;
    end else if (cur.ctrl[CB_RESTART] && cur.strap_done) begin
      nxt.st = AN_ADVERT;
      nxt.an_cmpl = 1'b0;
      nxt.lp_an_able = 1'b0;
    end

    // Software reset: whole block but the strap synchroniser back to reset image
    if (cur.ctrl[CB_RESET]) begin
      nxt = init_s();
      nxt.strap_sync = {cur.strap_sync[1:0], advert_strap_pin_i};
    end

    // Output stage flops
    nxt.flp = (nxt.st == AN_ADVERT);
    nxt.rx_dv = ~nxt.iso & mac_rx_dv_i;
    nxt.tx_en = ~nxt.iso & mac_tx_en_i;
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cur <= init_s();
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign prdata_o = cur.prdata;
  assign pready_o = cur.pready;
  assign pslverr_o = cur.pslverr;
  assign mac_rx_dv_o = cur.rx_dv;
  assign line_tx_en_o = cur.tx_en;
  assign isolate_o = cur.iso;
  assign flp_enable_o = cur.flp;
  assign tx_advert_o = cur.adv;
  assign speed_100_o = cur.spd100;
  assign full_duplex_o = cur.fdx;
  assign an_complete_o = cur.an_cmpl;

  ////////////////////////////////////////////////////////////////////
  // Checks

  // Full-duplex 100 wins whenever both sides offer it
  AST_RESOLVE_PRIO: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.st == AN_ADVERT && rx_page_valid_i && !rx_page_word_i[LP_NP]
     && common[3] && cur.ctrl[CB_AN_EN] && !cur.ctrl[CB_RESET]
     && !cur.ctrl[CB_RESTART])
    |=> (cur.spd100 && cur.fdx && cur.an_cmpl))
    else $error("resolution did not pick 100 full duplex");

  // Forced mode copies speed and duplex bits
  AST_FORCED_MODE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.st == AN_OFF && !cur.ctrl[CB_RESET])
    |=> (cur.spd100 == $past(cur.ctrl[CB_SPEED])
         && cur.fdx == $past(cur.ctrl[CB_DUPLEX])))
    else $error("forced mode does not follow control bits");

  // Resolved mode ignores control bits
  AST_AN_HOLDS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ((cur.st == AN_WAIT_LINK || cur.st == AN_GOOD) && cur.ctrl[CB_AN_EN]
     && !cur.ctrl[CB_RESET])
    |=> ($stable(cur.spd100) && $stable(cur.fdx)))
    else $error("negotiated mode changed on its own");

  // Received pages are captured
  AST_PAGE_CAPTURE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.st == AN_ADVERT && rx_page_valid_i && cur.ctrl[CB_AN_EN]
     && !cur.ctrl[CB_RESET])
    |=> (cur.lpar == $past(rx_page_word_i) && cur.page_rx))
    else $error("partner page not captured");

  // Parallel detection at 100 loads its fixed word
  AST_PD_WORD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.st == AN_ADVERT && !rx_page_valid_i && !cur.lp_an_able
     && link_100_i && !link_10_i && cur.ctrl[CB_AN_EN]
     && !cur.ctrl[CB_RESET] && !cur.ctrl[CB_RESTART])
    |=> (cur.lpar == PD_100_WORD && cur.st == AN_GOOD && cur.spd100))
    else $error("parallel detect word wrong");

  // Isolate timer counts down by one once the bit is clear
  AST_ISO_COUNT: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.iso_cnt != 15'h0000 && !cur.ctrl[CB_ISO] && !cur.ctrl[CB_RESET])
    |=> (cur.iso && cur.iso_cnt == $past(cur.iso_cnt) - 15'h0001))
    else $error("isolate timer stalled");

  // Bit clear starts the short release window
  AST_ISO_SW: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ($fell(cur.ctrl[CB_ISO]) && !cur.ctrl[CB_RESET])
    |-> (cur.iso && cur.iso_cnt == ISO_SW_LD))
    else $error("isolate release not armed");

  // Isolate drops the cycle after the timer empties
  AST_ISO_END: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.iso_cnt == 15'h0000 && !cur.ctrl[CB_ISO] && !cur.ctrl[CB_RESET])
    |=> !cur.iso)
    else $error("isolate held past its window");

  // Strap value lands in the ability field
  AST_STRAP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (!cur.strap_done && cur.strap_cnt == STRAP_SETTLE && !cur.ctrl[CB_RESET]
     && cur.strap_sync[1] == cur.strap_sync[2] && !wr_s)
    |=> (cur.strap_done && cur.adv[AB_HI:AB_LO]
         == ($past(cur.strap_sync[2]) ? STRAP_HI_ABIL : STRAP_LO_ABIL)))
    else $error("strap not loaded");

  // MAC side stays quiet while isolated
  AST_ISO_GATE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cur.iso |-> (!cur.rx_dv && !cur.tx_en))
    else $error("MAC activity while isolated");

  // Restart returns to advertising and clears itself
  AST_RESTART: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cur.ctrl[CB_RESTART] && cur.ctrl[CB_AN_EN] && cur.strap_done
     && !cur.ctrl[CB_RESET] && !wr_s)
    |=> (cur.st == AN_ADVERT && !cur.ctrl[CB_RESTART] && cur.flp))
    else $error("restart not honoured");

endmodule

// file: shared/phyan_pkg.sv
// Constants, types and register map for the negotiation control block
package phyan_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;
  localparam logic [4:0] IDX_ADV = 5'h04;
  localparam logic [4:0] IDX_LPAR = 5'h05;
  localparam logic [4:0] IDX_EXP = 5'h06;
  localparam logic [4:0] IDX_PSTS = 5'h10;

  // Control register bit positions
  localparam int CB_RESET = 15;
  localparam int CB_SPEED = 13;
  localparam int CB_AN_EN = 12;
  localparam int CB_ISO = 10;
  localparam int CB_RESTART = 9;
  localparam int CB_DUPLEX = 8;

  // Status register bit positions of the live bits
  localparam int SB_ANC = 5;
  localparam int SB_RFLT = 4;
  localparam int SB_LINK = 2;

  // Ability field in advertisement and partner words
  localparam int AB_HI = 8;
  localparam int AB_LO = 5;
  localparam int LP_RFLT = 13;
  localparam int LP_NP = 15;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h3100;
  localparam logic [15:0] ADV_RST = 16'h01e1;
  localparam logic [15:0] STAT_FIXED = 16'h7849;
  localparam logic [3:0] STRAP_LO_ABIL = 4'h5;
  localparam logic [3:0] STRAP_HI_ABIL = 4'hf;

  // Partner words loaded by parallel detection
  localparam logic [15:0] PD_100_WORD = 16'h0081;
  localparam logic [15:0] PD_10_WORD = 16'h0021;

  // Timing
  localparam int CLK_MHZ = 40;
  localparam int SW_ISO_US = 100;
  localparam int RST_ISO_US = 500;
  localparam int SW_ISO_CYC = SW_ISO_US * CLK_MHZ;
  localparam int RST_ISO_CYC_DEF = RST_ISO_US * CLK_MHZ;
  localparam logic [14:0] ISO_SW_LD = 15'(SW_ISO_CYC - 1);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Negotiation states
  typedef enum logic [1:0] {AN_OFF, AN_ADVERT, AN_WAIT_LINK, AN_GOOD} phyan_st_t;

  // Whole block state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] lpar;
    logic pdf;
    logic page_rx;
    logic lp_an_able;
    logic an_cmpl;
    phyan_st_t st;
    logic [14:0] iso_cnt;
    logic iso;
    logic [2:0] strap_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic spd100;
    logic fdx;
    logic flp;
    logic rx_dv;
    logic tx_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } phyan_state_t;

endpackage

// file: testbench/phyan_link_partner.sv
// Behavioural far-end link partner for the negotiation block
module phyan_link_partner (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic flp_i,
  input wire logic complete_i,
  input wire logic speed_100_i,
  input wire logic able_i,
  input wire logic slow_i,
  input wire logic [15:0] word_i,
  input wire logic [1:0] pd_link_i,
  input wire logic drop_i,
  output logic page_valid_o,
  output logic [15:0] page_word_o,
  output logic link_100_o,
  output logic link_10_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] wait_reg; // Cycles spent hearing bursts
  logic sent_reg; // One base page per advertising spell

  ////////////////////////////////////////////////////////////////////////////
  // Base page after a prompt or a slow reply time
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !flp_i) begin
      wait_reg <= 6'h00;
      sent_reg <= 1'b0;
      page_valid_o <= 1'b0;
    end else begin
      page_valid_o <= 1'b0;
      if (able_i && !sent_reg) begin
        wait_reg <= wait_reg + 6'h01;
        if (wait_reg == (slow_i ? 6'h1e : 6'h02)) begin
          page_valid_o <= 1'b1;
          sent_reg <= 1'b1;
        end
      end
    end
  end

  // Word is junk outside its pulse, so a late capture shows up
  assign page_word_o = page_valid_o ? word_i : ~word_i;

  // Negotiating partner shows link only at the resolved speed
  assign link_100_o = able_i ? (complete_i && speed_100_i && !drop_i) : pd_link_i[1];
  assign link_10_o = able_i ? (complete_i && !speed_100_i && !drop_i) : pd_link_i[0];
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the negotiation control block
module testbench import phyan_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned ISO_CYC = 50; // Short reset release count
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [6:0] paddr_i = 7'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic advert_strap_pin_i = 1'b0; // Low strap first
  logic [3:0] pstrb = 4'h3; // Byte strobes; one write uses the low lane alone
  logic mac_rx_dv_i = 1'b1, mac_tx_en_i = 1'b1; // Busy MAC throughout
  logic able = 1'b0, slow = 1'b0, drop = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [1:0] pd_link = 2'b00;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx_page_valid_i, link_100_i, link_10_i;
  logic [15:0] rx_page_word_i, tx_advert_o;
  logic mac_rx_dv_o, line_tx_en_o, isolate_o, flp_enable_o;
  logic speed_100_o, full_duplex_o, an_complete_o;
  int compares = 0, mismatches = 0, cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and the two parties
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well above the few thousand cycles needed
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[FAIL] %0t ns run timed out", $time);
      wrap_up();
    end
  end

  phyan_ctrl #(.RST_ISO_CYC(ISO_CYC)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .advert_strap_pin_i(advert_strap_pin_i),
    .rx_page_valid_i(rx_page_valid_i), .rx_page_word_i(rx_page_word_i),
    .link_100_i(link_100_i), .link_10_i(link_10_i), .mac_rx_dv_i(mac_rx_dv_i),
    .mac_tx_en_i(mac_tx_en_i), .mac_rx_dv_o(mac_rx_dv_o), .line_tx_en_o(line_tx_en_o),
    .isolate_o(isolate_o), .flp_enable_o(flp_enable_o), .tx_advert_o(tx_advert_o),
    .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .an_complete_o(an_complete_o));

  phyan_link_partner partner (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .flp_i(flp_enable_o), .complete_i(an_complete_o), .speed_100_i(speed_100_o),
    .able_i(able), .slow_i(slow), .word_i(word), .pd_link_i(pd_link), .drop_i(drop),
    .page_valid_o(rx_page_valid_i), .page_word_o(rx_page_word_i),
    .link_100_o(link_100_i), .link_10_o(link_10_i));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {16'h0000, wd};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // No cycle count assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic e;
    apb(1'b1, idx, wd, rd, e);
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, idx, 16'h0000, rd, e);
    check({rd[31:1], rd[0] | e}, {exp[31:1], exp[0] | (idx == 5'h1f)});
  endtask

  function automatic logic pick(input int which);
    return which == 0 ? isolate_o : (which == 1 ? flp_enable_o : an_complete_o);
  endfunction

  // Bounded wait for an output level; returns the cycles taken
  task automatic wait_out(input int which, input logic val, output int n);
    n = 0;
    while (pick(which) !== val && n < 6000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 6000) begin
      mismatches++;
      $display("[FAIL] %0t ns wait ran out", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    int n;
    @(posedge clk_sys_i);
    #1;
    check(isolate_o, 1'b1);
    check({mac_rx_dv_o, line_tx_en_o}, 2'b00);
    wait_out(0, 1'b0, n);
    check(n >= ISO_CYC - 4 && n <= ISO_CYC + 2, 1'b1);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({mac_rx_dv_o, line_tx_en_o}, 2'b11);
    rd_chk(IDX_CTRL, 32'h3100);
    rd_chk(IDX_ADV, 32'h00a1);
    pstrb <= 4'h1;
    wr(IDX_ADV, 16'h0161);
    rd_chk(IDX_ADV, 32'h0061);
    pstrb <= 4'h3;
    wr(IDX_STAT, 16'h0000);
    rd_chk(IDX_STAT, 32'h7849);
    rd_chk(5'h1f, 32'h0000);
  endtask

  task automatic t_iso();
    int n;
    wr(IDX_CTRL, 16'h3500);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({isolate_o, mac_rx_dv_o, line_tx_en_o}, 3'b100);
    wr(IDX_CTRL, 16'h3100);
    wait_out(0, 1'b0, n);
    check(n >= SW_ISO_CYC - 4 && n <= SW_ISO_CYC + 2, 1'b1);
  endtask

  task automatic t_strap();
    int n;
    advert_strap_pin_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    wr(IDX_CTRL, 16'h8000);
    // Isolate is low when the write lands; see it rise before timing the fall
    wait_out(0, 1'b1, n);
    wait_out(0, 1'b0, n);
    check(n >= ISO_CYC - 2 && n <= ISO_CYC + 4, 1'b1);
    rd_chk(IDX_ADV, 32'h01e1);
  endtask

  task automatic t_resolve();
    logic [15:0] adv [4] = '{16'h01e1, 16'h01e1, 16'h0061, 16'h0121};
    logic [15:0] lp [4] = '{16'h01e1, 16'h00a1, 16'h01e1, 16'h00e1};
    logic [1:0] mode [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    int n;
    for (int i = 0; i < 4; i++) begin
      able <= 1'b1;
      slow <= i[0];
      word <= lp[i];
      wr(IDX_ADV, adv[i]);
      #1;
      check(tx_advert_o, adv[i]);
      wr(IDX_CTRL, 16'h3300);
      wait_out(1, 1'b1, n);
      wait_out(2, 1'b1, n);
      repeat (3) @(posedge clk_sys_i);
      #1;
      check({speed_100_o, full_duplex_o}, mode[i]);
      rd_chk(IDX_LPAR, lp[i]);
      rd_chk(IDX_STAT, 32'h786d);
      rd_chk(IDX_PSTS, {27'h0, 2'b10, mode[i][0], ~mode[i][1], 1'b1});
      rd_chk(IDX_EXP, 32'h0003);
    end
  endtask

  task automatic t_forced();
    logic [15:0] ctl [3] = '{16'h2100, 16'h0000, 16'h2000};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_CTRL, ctl[i]);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check({speed_100_o, full_duplex_o, flp_enable_o}, {ctl[i][13], ctl[i][8], 1'b0});
    end
  endtask

  task automatic t_pd();
    int n;
    @(posedge clk_sys_i);
    able <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      pd_link <= i == 0 ? 2'b10 : 2'b01;
      wr(IDX_CTRL, 16'h1200);
      wait_out(2, 1'b1, n);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check({speed_100_o, full_duplex_o}, {i == 0, 1'b0});
      rd_chk(IDX_LPAR, i == 0 ? 32'h0081 : 32'h0021);
      rd_chk(IDX_EXP, 32'h0000);
      wr(IDX_CTRL, 16'h0000);
    end
    pd_link <= 2'b11;
    wr(IDX_CTRL, 16'h1200);
    repeat (10) @(posedge clk_sys_i);
    rd_chk(IDX_EXP, 32'h0010);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_iso();
    t_strap();
    t_resolve();
    t_forced();
    t_pd();
    wrap_up();
  end
endmodule
